/* bench/wdhr_watchdog_halt_reset_bench.sv */
// self-checking bench for the watchdog, power-down and reset control block
`timescale 1ns/10ps
`include "wdhr_regs.svh"
module wdhr_watchdog_halt_reset_bench;
  // design inputs
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  wdhr_pkg::wdhr_opt_s opt = '0;
  wdhr_pkg::wdhr_instr_s ins_q = '0;
  wdhr_pkg::wdhr_irq_s irq = '0;
  logic ext_n = 1'b1;
  logic rc = 1'b0;
  logic rtc = 1'b0;
  logic [7:0] pa = 8'hff;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // design outputs
  logic [7:0] rdata;
  logic [7:0] sel;
  logic core_rst, warm, stall, resume, irq_resp, sysosc, watchdog_rc_osc, to_f, pd_f;
  // bench state
  int n_fail = 0;
  int checks = 0;
  int seed = 32'he74981ee;
  int cyc = 0;
  int k;
  logic hit;
  logic [7:0] d;
  logic [31:0] r;
  // events waited on: reset, running, resume, interrupt answer, warm reset
  wire [4:0] ev = {warm, irq_resp, resume, !stall, core_rst};

  always #5 i_clock = ~i_clock;

  // oscillators derived from the clock keep runs repeatable; cycle ceiling stops a hang
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    rc <= cyc[2];
    rtc <= cyc[6];
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end

  // small counts so a full run stays short
  wdhr_watchdog_halt_reset #(.BASE_STAGES(2), .SST_CYCLES(8), .OPT_LOAD_CYCLES(2)) u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_opt(opt), .i_ext_reset_n(ext_n),
    .i_watchdog_rc_osc(rc), .i_low_freq_crystal_osc(rtc), .i_port_a(pa),
    .i_instr(ins_q), .i_irq(irq), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_core_reset(core_rst),
    .o_warm_reset(warm), .o_core_stall(stall), .o_resume(resume),
    .o_irq_respond(irq_resp), .o_sysosc_enable(sysosc), .o_watchdog_rc_osc_enable(watchdog_rc_osc),
    .o_timeout_flag(to_f), .o_powerdown_flag(pd_f), .o_prescale_select(sel));

  task stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // wait for event k within lim cycles
  task wt(input int k, input int lim);
    hit = 1'b0;
    repeat (lim) begin
      @(posedge i_clock);
      #1;
      if (ev[k] === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask

  task wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
  endtask

  // read answer stands only in the cycle after the strobe
  task rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  task ins(input logic [3:0] v);
    @(posedge i_clock);
    ins_q <= v;
    @(posedge i_clock);
    ins_q <= '0;
  endtask

  task boot(input logic en, input wdhr_pkg::wdhr_src_e src, input logic dual);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    opt <= '{en, src, 1'b1, dual, 8'h04};
    repeat (4) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wt(1, 100);
    chk("boot", 8'h01, {7'h0, hit});
  endtask

  task ext_rst;
    @(posedge i_clock);
    ext_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    ext_n <= 1'b1;
    wt(1, 60);
    chk("run", 8'h01, {7'h0, hit});
  endtask

  // m 1 feeds a dual pair in random order, otherwise the single clear
  task feed(input int m, input int reps, input logic e);
    int j;
    hit = 1'b0;
    for (j = 0; j < reps && !hit; j++) begin
      r = $random(seed);
      if (m == 1) begin
        ins(r[0] ? 4'b0100 : 4'b0010);
        ins(r[0] ? 4'b0010 : 4'b0100);
      end else begin
        ins(4'b1000);
      end
      wt(0, 40);
    end
    chk("reset", {7'h0, e}, {7'h0, hit});
  endtask

  initial begin
    boot(1'b1, wdhr_pkg::SRC_WDT_RC, 1'b0);
    rchk(`WDHR_ADDR_STATUS, 8'h00);
    rchk(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, `WDHR_WATCHDOG_PRESCALE_SELECT_RESET);
    // keep the prescale at its longest so random flags do not trip the watchdog
    repeat (6) begin
      r = $random(seed);
      wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, r[7:0] | 8'h07);
      rchk(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, r[7:0] | 8'h07);
    end
    wr_reg(`WDHR_ADDR_STATUS, 8'hff);
    rchk(`WDHR_ADDR_STATUS, 8'h00);
    rchk(4'h9, 8'h00);
    $display("test registers done");
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h01);
    feed(0, 8, 1'b0);
    wt(0, 300);
    chk("timeout", 8'h01, {7'h0, hit});
    wt(1, 100);
    rchk(`WDHR_ADDR_STATUS, 8'h20);
    rchk(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h07);
    $display("test single clear done");
    boot(1'b1, wdhr_pkg::SRC_WDT_RC, 1'b1);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h01);
    feed(1, 8, 1'b0);
    feed(0, 8, 1'b1);
    wt(1, 100);
    $display("test dual clear done");
    boot(1'b0, wdhr_pkg::SRC_WDT_RC, 1'b0);
    ins(4'b1000);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h00);
    wt(0, 400);
    chk("reset", 8'h00, {7'h0, hit});
    rchk(`WDHR_ADDR_STATUS, 8'h00);
    $display("test disabled done");
    boot(1'b1, wdhr_pkg::SRC_WDT_RC, 1'b0);
    ins(4'b0001);
    rchk(`WDHR_ADDR_STATUS, 8'h10);
    chk("sysosc", 8'h00, {7'h0, sysosc});
    @(posedge i_clock) pa <= 8'hfe;
    wt(1, 40);
    chk("wake", 8'h00, {7'h0, hit});
    @(posedge i_clock) pa <= 8'hfa;
    wt(2, 60);
    chk("resume", 8'h01, {7'h0, hit});
    rchk(`WDHR_ADDR_STATUS, 8'h10);
    @(posedge i_clock) pa <= 8'hff;
    $display("test port wake done");
    // first with room on the stack, then with the stack full
    for (k = 0; k < 2; k++) begin
      @(posedge i_clock) irq <= {3'b001, 3'b111, 1'b1, k[0]};
      ins(4'b0001);
      wt(1, 40);
      chk("wake", 8'h00, {7'h0, hit});
      @(posedge i_clock) irq <= {3'b011, 3'b111, 1'b1, k[0]};
      wt(3 - k, 60);
      chk("answer", 8'h01, {7'h0, hit});
      @(posedge i_clock) irq <= '0;
    end
    $display("test interrupt wake done");
    ins(4'b1000);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h00);
    ins(4'b0001);
    wt(4, 100);
    chk("warm", 8'h01, {7'h0, hit});
    chk("sel", 8'h00, sel);
    wt(1, 30);
    rchk(`WDHR_ADDR_STATUS, 8'h30);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h07);
    ins(4'b1000);
    rchk(`WDHR_ADDR_STATUS, 8'h00);
    $display("test warm wake done");
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'hf3);
    ins(4'b0001);
    ext_rst;
    rchk(`WDHR_ADDR_STATUS, 8'h10);
    rchk(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h07);
    ext_rst;
    rchk(`WDHR_ADDR_STATUS, 8'h10);
    $display("test pin reset done");
    // rtc source counts only while the rc plus rtc oscillator mode is chosen
    boot(1'b1, wdhr_pkg::SRC_RTC, 1'b0);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h00);
    wt(0, 700);
    chk("rtc", 8'h01, {7'h0, hit});
    wt(1, 100);
    @(posedge i_clock) opt.osc_rc_rtc <= 1'b0;
    ins(4'b1000);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h00);
    wt(0, 700);
    chk("rtc", 8'h00, {7'h0, hit});
    $display("test rtc source done");
    boot(1'b1, wdhr_pkg::SRC_INSTR, 1'b0);
    ins(4'b1000);
    wr_reg(`WDHR_ADDR_WATCHDOG_PRESCALE_SELECT, 8'h00);
    ins(4'b0001);
    wt(1, 300);
    chk("wake", 8'h00, {7'h0, hit});
    ext_rst;
    $display("test instruction clock done");
    stop_test;
  end
endmodule

/* bench/wdhr_watchdog_halt_reset_monitor.sv */
// assertion checker for the watchdog, power-down and reset control block
`timescale 1ns/10ps
module wdhr_watchdog_halt_reset_monitor #(
  parameter int SST_CYCLES = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // watched inputs
  input wire wdhr_pkg::wdhr_opt_s i_opt,
  input wire wdhr_pkg::wdhr_instr_s i_instr,
  input wire logic i_reg_rd,
  // watched outputs
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_core_reset,
  input wire logic o_warm_reset,
  input wire logic o_core_stall,
  input wire logic o_resume,
  input wire logic o_irq_respond,
  input wire logic o_sysosc_enable,
  input wire logic o_watchdog_rc_osc_enable,
  input wire logic o_timeout_flag,
  input wire logic o_powerdown_flag
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // a halt is only taken while running
  sequence s_halt_taken;
    i_instr.halt && !o_core_stall;
  endsequence
  // either way out of a wake-up delay
  sequence s_wake_out;
    o_resume || o_irq_respond;
  endsequence

  chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  chk_halt_entry: assert property (
    s_halt_taken |=> o_core_stall && !o_sysosc_enable && o_powerdown_flag && !o_timeout_flag)
    else $error("halt entry state wrong");
  chk_osc_enable: assert property (
    o_watchdog_rc_osc_enable == (i_opt.wdt_enable && i_opt.wdt_src == wdhr_pkg::SRC_WDT_RC))
    else $error("watchdog oscillator enable wrong");
  chk_warm_flags: assert property (
    o_warm_reset |-> ##[0:1] (o_timeout_flag && o_powerdown_flag && !o_core_reset))
    else $error("warm reset flags wrong");
  chk_warm_pulse: assert property (o_warm_reset |=> !o_warm_reset)
    else $error("warm reset longer than one cycle");
  chk_wake_delay: assert property (
    s_wake_out |-> !o_core_stall && $past(o_core_stall) && $past(o_core_stall, SST_CYCLES))
    else $error("wake answer without full delay");
  chk_one_answer: assert property (s_wake_out |-> !(o_resume && o_irq_respond))
    else $error("resume and interrupt answer together");
  chk_reset_hold: assert property (
    o_core_reset |-> o_core_stall && o_sysosc_enable && !o_resume)
    else $error("chip reset outputs wrong");
  chk_boot_delay: assert property (
    $fell(o_core_reset) |-> $past(o_core_stall, SST_CYCLES) && !o_core_stall)
    else $error("run began without start-up delay");
endmodule

bind wdhr_watchdog_halt_reset wdhr_watchdog_halt_reset_monitor #(.SST_CYCLES(SST_CYCLES)) u_mon (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_opt(i_opt), .i_instr(i_instr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_core_reset(o_core_reset),
  .o_warm_reset(o_warm_reset), .o_core_stall(o_core_stall), .o_resume(o_resume),
  .o_irq_respond(o_irq_respond), .o_sysosc_enable(o_sysosc_enable),
  .o_watchdog_rc_osc_enable(o_watchdog_rc_osc_enable), .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag));

/* verilog/wdhr_pkg.sv */
// types shared by the watchdog, power-down and reset control block
package wdhr_pkg;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RESET_HOLD = 5'b00001,
    ST_OPT_LOAD   = 5'b00010,
    ST_STARTUP    = 5'b00100,
    ST_RUN        = 5'b01000,
    ST_HALT       = 5'b10000
  } wdhr_state_e;

  // watchdog clock source option
  typedef enum logic [1:0] {
    SRC_WDT_RC = 2'h0,
    SRC_RTC    = 2'h1,
    SRC_INSTR  = 2'h2
  } wdhr_src_e;

  // what began the start-up delay
  typedef enum logic [1:0] {
    WAKE_COLD = 2'h0,
    WAKE_WARM = 2'h1,
    WAKE_PIN  = 2'h2,
    WAKE_IRQ  = 2'h3
  } wdhr_wake_e;

  // configuration options, fixed at build time of the part
  typedef struct packed {
    logic wdt_enable;
    wdhr_src_e wdt_src;
    logic osc_rc_rtc;
    logic clear_dual;
    logic [7:0] pa_wake_en;
  } wdhr_opt_s;

  // one-cycle instruction strobes from the core
  typedef struct packed {
    logic clear_instr;
    logic clear_first;
    logic clear_second;
    logic halt;
  } wdhr_instr_s;

  // interrupt view of the core: request flags, enables, stack state
  typedef struct packed {
    logic [2:0] req;
    logic [2:0] enable;
    logic master_en;
    logic stack_full;
  } wdhr_irq_s;

endpackage

/* verilog/wdhr_regs.svh */
// register offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDHR_REGS_SVH
`define WDHR_REGS_SVH

// register offsets on the plain register port
`define WDHR_ADDR_W 4
`define WDHR_ADDR_WATCHDOG_PRESCALE_SELECT 4'h0
`define WDHR_ADDR_STATUS 4'h1

// watchdog prescale select fields
`define WDHR_WATCHDOG_PRESCALE_SELECT_RESET 8'h07
`define WDHR_PS_MSB 2
`define WDHR_PS_LSB 0

// core status register flag positions
`define WDHR_STAT_PDF_BIT 4
`define WDHR_STAT_TO_BIT 5

// fixed base divider stages and instruction clock ratio
`define WDHR_BASE_STAGES 8
`define WDHR_INSTR_DIV 4

// start-up delay and option-load delay in system clock cycles
`define WDHR_SST_CYCLES 1024
`define WDHR_OPT_LOAD_CYCLES 16

// synchroniser reset levels: osc rc, osc rtc, reset pin, port a
`define WDHR_SYNC_RESET 11'h7fc

`endif

/* verilog/wdhr_watchdog_halt_reset.sv */
// watchdog timer, power-down entry and wake-up, reset cause flags and start-up delay
`timescale 1ns/10ps
`include "wdhr_regs.svh"

module wdhr_watchdog_halt_reset #(
  parameter int BASE_STAGES = `WDHR_BASE_STAGES,
  parameter int SST_CYCLES = `WDHR_SST_CYCLES,
  parameter int OPT_LOAD_CYCLES = `WDHR_OPT_LOAD_CYCLES
) (
  // clock and power-on reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // configuration options
  input wire wdhr_pkg::wdhr_opt_s i_opt,
  // pins and oscillators from outside this clock domain
  input wire logic i_ext_reset_n,
  input wire logic i_watchdog_rc_osc,
  input wire logic i_low_freq_crystal_osc,
  input wire logic [7:0] i_port_a,
  // core instruction strobes and interrupt state
  input wire wdhr_pkg::wdhr_instr_s i_instr,
  input wire wdhr_pkg::wdhr_irq_s i_irq,
  // register port
  input wire logic [`WDHR_ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // core control
  output logic o_core_reset,
  output logic o_warm_reset,
  output logic o_core_stall,
  output logic o_resume,
  output logic o_irq_respond,
  output logic o_sysosc_enable,
  output logic o_watchdog_rc_osc_enable,
  // status
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic [7:0] o_prescale_select
);

  localparam int WD_W = BASE_STAGES + 7;
  localparam int SST_W = $clog2(SST_CYCLES + OPT_LOAD_CYCLES + 1);
  localparam int SYNC_N = 11;

  // elaboration checks on the parameters
  initial begin
    if (BASE_STAGES < 1 || BASE_STAGES > 24) begin
      $error("base divider stages out of range");
    end
    if (SST_CYCLES < 1 || OPT_LOAD_CYCLES < 1) begin
      $error("delay counts must be at least one cycle");
    end
  end

  // terminal count of the whole chain for a prescale field value
  function automatic logic [WD_W-1:0] wd_last(input logic [2:0] sel);
    wd_last = WD_W'((32'h1 << (BASE_STAGES + 32'(sel))) - 32'h1);
  endfunction

  // delay reload value from a cycle count
  function automatic logic [SST_W-1:0] dly_last(input int cycles);
    dly_last = SST_W'(cycles - 1);
  endfunction

  wdhr_pkg::wdhr_state_e state_q;
  wdhr_pkg::wdhr_wake_e wake_q;
  logic [SYNC_N-1:0] sync1_q, sync2_q, sync3_q, filt_q;
  logic [SYNC_N-1:0] agree, rise, fall;
  logic rc_tick, rtc_tick, instr_tick, wd_tick;
  logic [1:0] div4_q;
  logic [WD_W-1:0] wd_cnt_q;
  logic [SST_W-1:0] dly_q;
  logic [1:0] dual_seen_q;
  logic [2:0] irq_block_q;
  logic [7:0] watchdog_prescale_select_q;
  logic to_q, pdf_q;
  logic ext_rst_low, pa_wake, irq_wake, wd_ovf, clear_eff, halt_go, dly_done;
  logic warm_q, resume_q, irq_resp_q;
  logic [7:0] rdata_q;

  // three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= `WDHR_SYNC_RESET;
      sync2_q <= `WDHR_SYNC_RESET;
      sync3_q <= `WDHR_SYNC_RESET;
      filt_q <= `WDHR_SYNC_RESET;
    end else begin
      sync1_q <= {i_port_a, i_ext_reset_n, i_low_freq_crystal_osc, i_watchdog_rc_osc};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= agree & sync3_q | ~agree & filt_q;
    end
  end

  // edges of the filtered inputs, one cycle each
  assign agree = ~(sync2_q ^ sync3_q);
  assign rise = agree & sync3_q & ~filt_q;
  assign fall = agree & ~sync3_q & filt_q;
  assign rc_tick = rise[0];
  assign rtc_tick = rise[1];
  assign ext_rst_low = ~filt_q[2];

  // port wake edge
  // a falling edge on any enabled port a bit
  assign pa_wake = |(fall[10:3] & i_opt.pa_wake_en);

  // pending requests blocked
  // requests already set at halt entry are masked out of the wake term
  assign irq_wake = |(i_irq.req & ~irq_block_q);

  // instruction clock: system clock divided by four
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div4_q <= 2'h0;
    end else if (state_q != wdhr_pkg::ST_HALT) begin
      div4_q <= div4_q + 2'h1;
    end
  end

  // instruction clock stops
  // the divider is frozen in power-down, so this source gives no ticks there
  assign instr_tick = (div4_q == 2'(`WDHR_INSTR_DIV - 1)) && (state_q != wdhr_pkg::ST_HALT);

  always_comb begin
    case (i_opt.wdt_src)
      wdhr_pkg::SRC_WDT_RC: wd_tick = rc_tick;
      wdhr_pkg::SRC_RTC: wd_tick = rtc_tick & i_opt.osc_rc_rtc;
      wdhr_pkg::SRC_INSTR: wd_tick = instr_tick;
      default: wd_tick = 1'b0;
    endcase
  end

  // oscillator control
  // system oscillator off in power-down; watchdog rc kept only when it is the source
  assign o_sysosc_enable = (state_q != wdhr_pkg::ST_HALT);
  assign o_watchdog_rc_osc_enable = i_opt.wdt_enable && (i_opt.wdt_src == wdhr_pkg::SRC_WDT_RC);

  assign halt_go = (state_q == wdhr_pkg::ST_RUN) && i_instr.halt;
  always_comb begin
    clear_eff = 1'b0;
    if (i_opt.wdt_enable && state_q == wdhr_pkg::ST_RUN) begin
      if (!i_opt.clear_dual) begin
        clear_eff = i_instr.clear_instr;
      end else begin
        clear_eff = (dual_seen_q[0] | i_instr.clear_first) &
                    (dual_seen_q[1] | i_instr.clear_second);
      end
    end
  end

  // dual clear record
  // either order counts; the record empties once the pair completes
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dual_seen_q <= 2'h0;
    end else if (clear_eff || !i_opt.clear_dual || state_q != wdhr_pkg::ST_RUN) begin
      dual_seen_q <= 2'h0;
    end else if (i_opt.wdt_enable) begin
      dual_seen_q <= dual_seen_q | {i_instr.clear_second, i_instr.clear_first};
    end
  end

  // prescale extends chain
  // base stages and prescaler form one chain; the field picks its last bit
  assign wd_ovf = i_opt.wdt_enable && wd_tick &&
                  (wd_cnt_q == wd_last(watchdog_prescale_select_q[`WDHR_PS_MSB:`WDHR_PS_LSB])) &&
                  (state_q == wdhr_pkg::ST_RUN || state_q == wdhr_pkg::ST_HALT);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt_q <= '0;
    end else if (!i_opt.wdt_enable || ext_rst_low || clear_eff || halt_go || wd_ovf ||
                 state_q == wdhr_pkg::ST_RESET_HOLD || state_q == wdhr_pkg::ST_OPT_LOAD) begin
      wd_cnt_q <= '0;
    end else if (wd_tick) begin
      wd_cnt_q <= wd_cnt_q + WD_W'(1);
    end
  end

  // requests pending when halt is entered lose their wake ability
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_block_q <= 3'h0;
    end else if (halt_go) begin
      irq_block_q <= i_irq.req;
    end else if (state_q != wdhr_pkg::ST_HALT) begin
      irq_block_q <= 3'h0;
    end
  end

  // option load skipped on wake from halt
  // sequencer: the reset pin has top priority, then overflow, then wake terms
  assign dly_done = (dly_q == '0);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= wdhr_pkg::ST_OPT_LOAD;
      wake_q <= wdhr_pkg::WAKE_COLD;
      dly_q <= dly_last(OPT_LOAD_CYCLES);
    end else if (ext_rst_low) begin
      state_q <= wdhr_pkg::ST_RESET_HOLD;
      wake_q <= wdhr_pkg::WAKE_COLD;
      dly_q <= dly_last(OPT_LOAD_CYCLES);
    end else begin
      case (state_q)
        wdhr_pkg::ST_RESET_HOLD: begin
          state_q <= wdhr_pkg::ST_OPT_LOAD;
        end
        wdhr_pkg::ST_OPT_LOAD: begin
          if (dly_done) begin
            state_q <= wdhr_pkg::ST_STARTUP;
            dly_q <= dly_last(SST_CYCLES);
          end else begin
            dly_q <= dly_q - SST_W'(1);
          end
        end
        wdhr_pkg::ST_STARTUP: begin
          if (dly_done) begin
            state_q <= wdhr_pkg::ST_RUN;
          end else begin
            dly_q <= dly_q - SST_W'(1);
          end
        end
        wdhr_pkg::ST_RUN: begin
          if (wd_ovf) begin
            state_q <= wdhr_pkg::ST_OPT_LOAD;
            wake_q <= wdhr_pkg::WAKE_COLD;
            dly_q <= dly_last(OPT_LOAD_CYCLES);
          end else if (halt_go) begin
            state_q <= wdhr_pkg::ST_HALT;
          end
        end
        wdhr_pkg::ST_HALT: begin
          if (wd_ovf || pa_wake || irq_wake) begin
            state_q <= wdhr_pkg::ST_STARTUP;
            dly_q <= dly_last(SST_CYCLES);
            if (wd_ovf) begin
              wake_q <= wdhr_pkg::WAKE_WARM;
            end else if (pa_wake) begin
              wake_q <= wdhr_pkg::WAKE_PIN;
            end else begin
              wake_q <= wdhr_pkg::WAKE_IRQ;
            end
          end
        end
        default: begin
          state_q <= wdhr_pkg::ST_RESET_HOLD;
        end
      endcase
    end
  end

  // pulses at the end of a wake-up dummy period, and the warm reset strobe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_q <= 1'b0;
      resume_q <= 1'b0;
      irq_resp_q <= 1'b0;
    end else begin
      warm_q <= !ext_rst_low && state_q == wdhr_pkg::ST_HALT && wd_ovf;
      resume_q <= 1'b0;
      irq_resp_q <= 1'b0;
      if (!ext_rst_low && state_q == wdhr_pkg::ST_STARTUP && dly_done) begin
        case (wake_q)
          wdhr_pkg::WAKE_PIN: resume_q <= 1'b1;
          wdhr_pkg::WAKE_IRQ: begin
            if (i_irq.master_en && |(i_irq.req & i_irq.enable) && !i_irq.stack_full) begin
              irq_resp_q <= 1'b1;
            end else begin
              resume_q <= 1'b1;
            end
          end
          default: begin
            resume_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // reset cause encoding
  // set wins over clear; an external reset in halt forces 01, while running keeps them
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end else if (ext_rst_low) begin
      if (state_q == wdhr_pkg::ST_HALT) begin
        to_q <= 1'b0;
        pdf_q <= 1'b1;
      end
    end else if (wd_ovf) begin
      to_q <= 1'b1;
    end else if (halt_go) begin
      to_q <= 1'b0;
      pdf_q <= 1'b1;
    end else if (clear_eff) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
    end
  end

  // user flag bits
  // select register: chip resets restore its default, warm reset leaves it
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      watchdog_prescale_select_q <= `WDHR_WATCHDOG_PRESCALE_SELECT_RESET;
    end else if (state_q == wdhr_pkg::ST_RESET_HOLD || state_q == wdhr_pkg::ST_OPT_LOAD) begin
      watchdog_prescale_select_q <= `WDHR_WATCHDOG_PRESCALE_SELECT_RESET;
    end else if (i_reg_wr && i_reg_addr == `WDHR_ADDR_WATCHDOG_PRESCALE_SELECT) begin
      watchdog_prescale_select_q <= i_reg_wdata;
    end
  end

  // status bit positions
  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      rdata_q <= 8'h00;
      if (i_reg_addr == `WDHR_ADDR_WATCHDOG_PRESCALE_SELECT) begin
        rdata_q <= watchdog_prescale_select_q;
      end else if (i_reg_addr == `WDHR_ADDR_STATUS) begin
        rdata_q[`WDHR_STAT_PDF_BIT] <= pdf_q;
        rdata_q[`WDHR_STAT_TO_BIT] <= to_q;
      end
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // core held in reset
  // core reset spans the pin low time, option load and the cold start-up delay
  assign o_core_reset = state_q == wdhr_pkg::ST_RESET_HOLD ||
                        state_q == wdhr_pkg::ST_OPT_LOAD ||
                        (state_q == wdhr_pkg::ST_STARTUP && wake_q == wdhr_pkg::WAKE_COLD);
  // core does not execute in halt or during any start-up delay
  assign o_core_stall = state_q != wdhr_pkg::ST_RUN;

  // outputs from flip-flops
  assign o_warm_reset = warm_q;
  assign o_resume = resume_q;
  assign o_irq_respond = irq_resp_q;
  assign o_timeout_flag = to_q;
  assign o_powerdown_flag = pdf_q;
  assign o_prescale_select = watchdog_prescale_select_q;
  assign o_reg_rdata = rdata_q;

endmodule
